// ---- logic/toh_device.sv ----
`timescale 1ns/100ps
// Behaviour
// - Enabled bits replaced by external data
// - Enable chooses overwrite per bit
// - T3 sequence covers X P M F C
// - G.751 covers alignment, alarm, national bits
// - G.832 covers all overhead bytes
// - Frame start marks first overhead bit
// - Sequence begins on marked falling edge
// - Device samples inputs on falling edge
// - External logic acts on rising edge
// - Received overhead bits output serially
// - C bits output even in M23 mode
// - Receive outputs change on falling edge
// - External logic captures on rising edge
// - Port runs only in T3/E3 modes
// - Every port signal has polarity inversion
// - Receive frame start marks first bit
module toh_device (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire toh_pkg::toh_mode_type        mode,
    input  wire logic                         m_two_three_multiplex,
    input  wire logic [toh_pkg::TOH_INV_W-1:0] pol_inv,
    input  wire logic                         tx_gen_bit,
    output logic                              tx_bit_valid,
    output logic                              tx_bit_out,
    output logic                              tx_bit_ovr,
    input  wire logic                         rx_bit_valid,
    output logic                              rx_bit_ready,
    input  wire logic                         rx_bit,
    toh_if.dev                                port
);
    // ========================================
    // Next bit position, wrapping at the frame length
    function automatic logic [6:0] next_pos(input logic [6:0] pos,
                                            input logic [6:0] len);
        next_pos = (pos + 7'h01 >= len) ? toh_pkg::TOH_POS_RESET
                                        : pos + 7'h01;
    endfunction

    // ========================================
    // Overhead clock divider and bit position
    toh_pkg::toh_mode_type mode_q;
    logic [3:0] div_q;
    logic       oclk_q;
    logic [6:0] tpos_q;
    logic [6:0] rpos_q;
    logic [6:0] len_w;
    logic       run_w;
    logic       tick_w;
    logic       fall_w;

    // Mode changes take effect one clock later, mid-frame; position resets only while mode is off
    assign len_w  = toh_pkg::toh_len(mode_q);
    assign run_w  = (mode_q != toh_pkg::TOH_MODE_OFF);
    assign tick_w = run_w && (div_q == toh_pkg::TOH_HALF_CYCLES);
    assign fall_w = tick_w && oclk_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= toh_pkg::TOH_MODE_OFF;
            div_q  <= toh_pkg::TOH_DIV_RESET;
            oclk_q <= 1'b0;
        end else begin
            mode_q <= mode;
            div_q  <= tick_w || !run_w ? toh_pkg::TOH_DIV_RESET
                                       : div_q + 4'h1;
            oclk_q <= run_w ? oclk_q ^ tick_w : 1'b0;
        end
    end

    // ========================================
    // Transmit side: sample on falling edge
    // Insert pins move on the far end's clock edge: two flops each
    logic       s_dat1_q;
    logic       s_dat2_q;
    logic       s_en1_q;
    logic       s_en2_q;
    logic       tsof_q;
    logic       ins_w;
    logic [6:0] tnext_w;

    assign tnext_w = next_pos(tpos_q, len_w);
    // Insert enable taken per bit with polarity option
    assign ins_w = s_en2_q ^ pol_inv[toh_pkg::TOH_INV_TX_EN];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_dat1_q <= 1'b0;
            s_dat2_q <= 1'b0;
            s_en1_q  <= 1'b0;
            s_en2_q  <= 1'b0;
        end else begin
            s_dat1_q <= port.tx_ovh_data_in;
            s_dat2_q <= s_dat1_q;
            s_en1_q  <= port.tx_ovh_insert_en;
            s_en2_q  <= s_en1_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tpos_q       <= toh_pkg::TOH_POS_RESET;
            tsof_q       <= 1'b0;
            tx_bit_valid <= 1'b0;
            tx_bit_out   <= 1'b0;
            tx_bit_ovr   <= 1'b0;
        end else begin
            tx_bit_valid <= fall_w;
            if (!run_w) begin
                tpos_q <= toh_pkg::TOH_POS_RESET;
                tsof_q <= 1'b0;
            end else if (fall_w) begin
                // Covered bit set is the len_w positions ..
                tpos_q     <= tnext_w;
                tsof_q     <= (tnext_w == toh_pkg::TOH_POS_RESET);
                tx_bit_ovr <= ins_w;
                tx_bit_out <= ins_w ? s_dat2_q ^
                              pol_inv[toh_pkg::TOH_INV_TX_DATA]
                                    : tx_gen_bit;
            end
        end
    end

    // ========================================
    // Receive side: two-entry buffer then shift out on falling edge
    logic [1:0] buf_q;
    logic       rd_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic       push_w;
    logic       pop_w;
    logic       rdat_q;
    logic       rsof_q;
    logic [6:0] rnext_w;

    assign push_w  = rx_bit_valid && rx_bit_ready;
    // A missing bit holds the last value rather than slipping the frame
    assign pop_w   = fall_w && (cnt_q != 2'h0);
    assign cnt_d   = cnt_q + {1'b0, push_w} - {1'b0, pop_w};
    assign rnext_w = next_pos(rpos_q, len_w);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            buf_q        <= 2'h0;
            rd_q         <= 1'b0;
            cnt_q        <= 2'h0;
            rx_bit_ready <= 1'b0;
        end else begin
            if (push_w)
                buf_q[rd_q ^ cnt_q[0]] <= rx_bit;
            if (pop_w)
                rd_q <= ~rd_q;
            cnt_q        <= cnt_d;
            // Ready from a flop: full is known one cycle ahead via cnt_d
            rx_bit_ready <= (cnt_d != 2'h2);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rpos_q <= toh_pkg::TOH_POS_RESET;
            rdat_q <= 1'b0;
            rsof_q <= 1'b0;
        end else if (!run_w) begin
            rpos_q <= toh_pkg::TOH_POS_RESET;
            rsof_q <= 1'b0;
        end else if (fall_w) begin
            // C bits come through in multiplex mode too
            rpos_q <= rnext_w;
            rsof_q <= (rnext_w == toh_pkg::TOH_POS_RESET);
            if (cnt_q != 2'h0)
                rdat_q <= buf_q[rd_q];
        end
    end

    // ========================================
    // Pin polarity, all from flip-flops
    logic tclk_q;
    logic rclk_q;
    logic tsofp_q;
    logic rsofp_q;
    logic rdatp_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tclk_q  <= 1'b0;
            rclk_q  <= 1'b0;
            tsofp_q <= 1'b0;
            rsofp_q <= 1'b0;
            rdatp_q <= 1'b0;
        end else begin
            tclk_q  <= (oclk_q ^ tick_w) ^ pol_inv[toh_pkg::TOH_INV_TX_CLK];
            rclk_q  <= (oclk_q ^ tick_w) ^ pol_inv[toh_pkg::TOH_INV_RX_CLK];
            tsofp_q <= (fall_w ? (tnext_w == 7'h00) && run_w : tsof_q)
                       ^ pol_inv[toh_pkg::TOH_INV_TX_SOF];
            rsofp_q <= (fall_w ? (rnext_w == 7'h00) && run_w : rsof_q)
                       ^ pol_inv[toh_pkg::TOH_INV_RX_SOF];
            rdatp_q <= ((pop_w ? buf_q[rd_q] : rdat_q))
                       ^ pol_inv[toh_pkg::TOH_INV_RX_DATA];
        end
    end

    assign port.tx_ovh_clk         = tclk_q;
    assign port.rx_ovh_clk         = rclk_q;
    assign port.tx_ovh_frame_start = tsofp_q;
    assign port.rx_ovh_frame_start = rsofp_q;
    assign port.rx_ovh_data_out    = rdatp_q;
endmodule

// ---- logic/toh_pkg.sv ----
package toh_pkg;

    // ========================================
    // Framing modes
    typedef enum logic [1:0] {
        TOH_MODE_OFF  = 2'b00,
        TOH_MODE_T3   = 2'b01,
        TOH_MODE_G751 = 2'b10,
        TOH_MODE_G832 = 2'b11
    } toh_mode_type;

    // ========================================
    // Overhead bits per frame in each mode
    localparam logic [6:0] TOH_LEN_T3   = 7'h38;
    localparam logic [6:0] TOH_LEN_G751 = 7'h0c;
    localparam logic [6:0] TOH_LEN_G832 = 7'h38;

    // ========================================
    // Overhead clock divider: half period in system clocks, less one
    localparam int         TOH_CLK_HZ      = 10000000;
    localparam int         TOH_OVH_HZ      = 625000;
    localparam logic [3:0] TOH_HALF_CYCLES =
        4'(TOH_CLK_HZ / TOH_OVH_HZ / 2 - 1);

    // ========================================
    // Reset values
    localparam logic [6:0] TOH_POS_RESET   = 7'h00;
    localparam logic [3:0] TOH_DIV_RESET   = 4'h0;

    // ========================================
    // Inversion vector bit positions
    localparam int TOH_INV_TX_DATA  = 0;
    localparam int TOH_INV_TX_EN    = 1;
    localparam int TOH_INV_TX_CLK   = 2;
    localparam int TOH_INV_TX_SOF   = 3;
    localparam int TOH_INV_RX_DATA  = 4;
    localparam int TOH_INV_RX_CLK   = 5;
    localparam int TOH_INV_RX_SOF   = 6;
    localparam int TOH_INV_W        = 7;

    function automatic logic [6:0] toh_len(input toh_mode_type mode);
        case (mode)
            TOH_MODE_T3:   toh_len = TOH_LEN_T3;
            TOH_MODE_G751: toh_len = TOH_LEN_G751;
            TOH_MODE_G832: toh_len = TOH_LEN_G832;
            default:       toh_len = 7'h01;
        endcase
    endfunction

endpackage

// ---- logic/toh_if.sv ----
`timescale 1ns/100ps
interface toh_if;
    logic tx_ovh_clk;
    logic tx_ovh_frame_start;
    logic tx_ovh_data_in;
    logic tx_ovh_insert_en;
    logic rx_ovh_clk;
    logic rx_ovh_frame_start;
    logic rx_ovh_data_out;

    modport dev (
        output tx_ovh_clk,
        output tx_ovh_frame_start,
        input  tx_ovh_data_in,
        input  tx_ovh_insert_en,
        output rx_ovh_clk,
        output rx_ovh_frame_start,
        output rx_ovh_data_out
    );

    modport ext (
        input  tx_ovh_clk,
        input  tx_ovh_frame_start,
        output tx_ovh_data_in,
        output tx_ovh_insert_en,
        input  rx_ovh_clk,
        input  rx_ovh_frame_start,
        input  rx_ovh_data_out
    );
endinterface

// ---- logic/toh_external.sv ----
`timescale 1ns/100ps
module toh_external (
    input  wire logic tx_ovh_clk_link,
    input  wire logic rst_b,
    input  wire logic ins_data,
    input  wire logic ins_en,
    output logic      ins_frame_start,
    output logic      cap_data,
    output logic      cap_frame_start,
    toh_if.ext        port
);
    // ========================================
    // Transmit: drive on rising edge, device samples on falling
    logic dat_q, en_q, sof_q;
    always_ff @(posedge tx_ovh_clk_link or negedge rst_b) begin
        if (!rst_b) begin
            dat_q <= 1'b0;
            en_q  <= 1'b0;
            sof_q <= 1'b0;
        end else begin
            sof_q <= port.tx_ovh_frame_start;
            dat_q <= ins_data;
            en_q  <= ins_en;
        end
    end
    assign port.tx_ovh_data_in   = dat_q;
    assign port.tx_ovh_insert_en = en_q;
    assign ins_frame_start       = sof_q;

    // ========================================
    // Receive: capture on rising edge
    logic cd_q, cs_q;
    always_ff @(posedge port.rx_ovh_clk or negedge rst_b) begin
        if (!rst_b) begin
            cd_q <= 1'b0;
            cs_q <= 1'b0;
        end else begin
            cd_q <= port.rx_ovh_data_out;
            cs_q <= port.rx_ovh_frame_start;
        end
    end
    assign cap_data        = cd_q;
    assign cap_frame_start = cs_q;
endmodule

// ---- tb/toh_checker.sv ----
`timescale 1ns/100ps
module toh_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tx_ovh_clk,
    input wire logic tx_ovh_frame_start,
    input wire logic tx_ovh_data_in,
    input wire logic tx_ovh_insert_en,
    input wire logic rx_ovh_clk,
    input wire logic rx_ovh_frame_start,
    input wire logic rx_ovh_data_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ========================================
    // Overhead clock falls since the last frame start
    // Mode is not visible here, so any legal frame length passes
    logic       clk_q;
    logic       seen_q;
    logic [6:0] falls_q;
    logic [6:0] falls_d;
    wire        fall_w = clk_q & ~tx_ovh_clk;
    assign falls_d = !fall_w ? falls_q :
                     (tx_ovh_frame_start ? 7'h00 : falls_q + 7'h01);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_q   <= 1'b0;
            seen_q  <= 1'b0;
            falls_q <= 7'h00;
        end else begin
            clk_q   <= tx_ovh_clk;
            seen_q  <= seen_q | (fall_w & tx_ovh_frame_start);
            falls_q <= falls_d;
        end
    end
    // ========================================
    // Properties
    sequence s_tx_low;
        (!tx_ovh_clk)[*8] ##1 tx_ovh_clk;
    endsequence
    sequence s_rx_low;
        (!rx_ovh_clk)[*8] ##1 rx_ovh_clk;
    endsequence
    property p_tx_half; $fell(tx_ovh_clk) |-> s_tx_low; endproperty
    property p_rx_half; $fell(rx_ovh_clk) |-> s_rx_low; endproperty
    property p_tx_sof_edge;
        $changed(tx_ovh_frame_start) |-> $fell(tx_ovh_clk);
    endproperty
    property p_rx_edge;
        $changed(rx_ovh_data_out) || $changed(rx_ovh_frame_start)
            |-> $fell(rx_ovh_clk);
    endproperty
    property p_ins_edge;
        $changed(tx_ovh_data_in) || $changed(tx_ovh_insert_en)
            |-> $rose(tx_ovh_clk);
    endproperty
    property p_tx_sof_wide;
        $rose(tx_ovh_frame_start) |-> ##16 $fell(tx_ovh_frame_start);
    endproperty
    property p_rx_sof_wide;
        $rose(rx_ovh_frame_start) |-> ##16 $fell(rx_ovh_frame_start);
    endproperty
    property p_frame_len;
        fall_w && tx_ovh_frame_start && seen_q
            |-> falls_q == 7'h0b || falls_q == 7'h37;
    endproperty
    a_tx_half: assert property (p_tx_half)
        else $error("tx overhead clock low phase wrong");
    a_rx_half: assert property (p_rx_half)
        else $error("rx overhead clock low phase wrong");
    a_tx_sof_edge: assert property (p_tx_sof_edge)
        else $error("tx frame start moved off a falling edge");
    a_rx_edge: assert property (p_rx_edge)
        else $error("rx outputs moved off a falling edge");
    a_ins_edge: assert property (p_ins_edge)
        else $error("insert pins moved off a rising edge");
    a_tx_sof_wide: assert property (p_tx_sof_wide)
        else $error("tx frame start width wrong");
    a_rx_sof_wide: assert property (p_rx_sof_wide)
        else $error("rx frame start width wrong");
    a_frame_len: assert property (p_frame_len)
        else $error("overhead frame length wrong");
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
    // ========================================
    // Stimulus and observation
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    toh_pkg::toh_mode_type mode = toh_pkg::TOH_MODE_OFF;
    logic                  m23 = 1'b0;
    logic [6:0]            pol_inv = 7'h00;
    logic                  gen = 1'b0;
    logic                  rx_valid = 1'b0;
    logic                  rx_bit = 1'b0;
    logic                  ins_data = 1'b0;
    logic                  ins_en = 1'b0;
    logic                  a_gen, a_data, a_en, seen, ptx, prx, psof, rx_exp;
    logic [6:0]            vcnt;
    logic [31:0]           seed = 32'hf1309e55;
    logic                  rxq[$];
    int                    fail_count = 0;
    int                    checked = 0;
    wire                   tx_valid, tx_out, tx_ovr, rx_ready;
    wire                   ins_sof, cap_data, cap_sof;
    toh_if link ();
    toh_device toh_device_inst (.clk(clk), .rst_b(rst_b), .mode(mode),
        .m_two_three_multiplex(m23), .pol_inv(pol_inv), .tx_gen_bit(gen),
        .tx_bit_valid(tx_valid), .tx_bit_out(tx_out), .tx_bit_ovr(tx_ovr),
        .rx_bit_valid(rx_valid), .rx_bit_ready(rx_ready), .rx_bit(rx_bit),
        .port(link));
    toh_external toh_external_inst (.tx_ovh_clk_link(link.tx_ovh_clk),
        .rst_b(rst_b), .ins_data(ins_data), .ins_en(ins_en),
        .ins_frame_start(ins_sof), .cap_data(cap_data),
        .cap_frame_start(cap_sof), .port(link));
    toh_checker toh_checker_inst (.clk(clk), .rst_b(rst_b),
        .tx_ovh_clk(link.tx_ovh_clk),
        .tx_ovh_frame_start(link.tx_ovh_frame_start),
        .tx_ovh_data_in(link.tx_ovh_data_in),
        .tx_ovh_insert_en(link.tx_ovh_insert_en),
        .rx_ovh_clk(link.rx_ovh_clk),
        .rx_ovh_frame_start(link.rx_ovh_frame_start),
        .rx_ovh_data_out(link.rx_ovh_data_out));
    always #50 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic exp_en(input logic e, input logic [6:0] inv);
        return e ^ inv[toh_pkg::TOH_INV_TX_EN];
    endfunction
    function automatic logic exp_tx(input logic g, d, e,
                                    input logic [6:0] inv);
        return exp_en(e, inv) ? d ^ inv[toh_pkg::TOH_INV_TX_DATA] : g;
    endfunction
    function automatic logic [6:0] exp_len(input toh_pkg::toh_mode_type m);
        if (m == toh_pkg::TOH_MODE_G751) return toh_pkg::TOH_LEN_G751;
        if (m == toh_pkg::TOH_MODE_G832) return toh_pkg::TOH_LEN_G832;
        return toh_pkg::TOH_LEN_T3;
    endfunction
    // ========================================
    // New inputs only right after a bit is taken, so each stays whole
    // for one overhead period
    always @(posedge clk) begin
        if (!rst_b) begin
            {a_gen, a_data, a_en, seen, vcnt} = 11'h000;
            rxq.delete();
            {gen, ins_data, ins_en, rx_valid} <= 4'h0;
        end else begin
            rx_valid <= 1'b1;
            if (tx_valid === 1'b1) begin
                `CHK(tx_out, exp_tx(a_gen, a_data, a_en, pol_inv));
                `CHK(tx_ovr, exp_en(a_en, pol_inv));
                seed = xs(seed);
                {a_gen, a_data, a_en} = seed[2:0];
                {gen, ins_data, ins_en} <= seed[2:0];
                vcnt = vcnt + 7'h01;
            end
            if (prx && !link.rx_ovh_clk && rxq.size() > 0) begin
                rx_exp = rxq.pop_front() ^ pol_inv[toh_pkg::TOH_INV_RX_DATA];
                `CHK(link.rx_ovh_data_out, rx_exp);
            end
            if (rx_valid && rx_ready === 1'b1) begin
                rxq.push_back(rx_bit);
                seed = xs(seed);
                rx_bit <= seed[5];
            end
            if (!prx && link.rx_ovh_clk) begin
                `CHK(cap_data, link.rx_ovh_data_out);
                `CHK(cap_sof, link.rx_ovh_frame_start);
            end
            if (!ptx && link.tx_ovh_clk)
                `CHK(ins_sof, link.tx_ovh_frame_start);
            if (!psof && link.tx_ovh_frame_start) begin
                if (seen) `CHK(vcnt, exp_len(mode));
                vcnt = 7'h00;
                seen = 1'b1;
            end
        end
        {ptx, prx, psof} = {link.tx_ovh_clk, link.rx_ovh_clk,
                            link.tx_ovh_frame_start};
    end
    // ========================================
    // Sequence
    task automatic run(input toh_pkg::toh_mode_type m, input logic [6:0] inv,
                       input int n);
        @(posedge clk);
        rst_b <= 1'b0;
        mode <= m;
        pol_inv <= inv;
        seed = xs(seed);
        m23 <= seed[4];
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        run(toh_pkg::TOH_MODE_T3, 7'h00, 2700);
        run(toh_pkg::TOH_MODE_G751, 7'h00, 800);
        run(toh_pkg::TOH_MODE_G832, 7'h00, 2700);
        run(toh_pkg::TOH_MODE_T3, 7'h03, 1840);
        run(toh_pkg::TOH_MODE_OFF, 7'h00, 60);
        `CHK({link.tx_ovh_clk, link.rx_ovh_clk, vcnt}, 9'h000);
        run(toh_pkg::TOH_MODE_OFF, 7'h24, 60);
        `CHK({link.tx_ovh_clk, link.rx_ovh_clk}, 2'h3);
        wrap_up();
    end
    initial begin
        #2000000;
        fail_count++;
        wrap_up();
    end
endmodule
